// >>> dv/ccpr_partner.sv
// far-end port model: terminations and supply of the attached partner
`timescale 1ns/1ps
module ccpr_partner (
  input  wire logic       sinkOn,     // far end presents pull-downs
  input  wire logic       srcOn,      // far end presents pull-ups
  input  wire logic       vbusOn,     // far end drives the supply
  input  wire logic       flip,       // cable turned: line 2 carries channel
  input  wire logic [1:0] lvl,        // far-end pull-up strength
  input  wire logic       rpEnable1,
  input  wire logic       rpEnable2,
  input  wire logic       rdEnable1,
  input  wire logic       rdEnable2,
  input  wire logic       vbusEnable,
  output logic            ccRd1,
  output logic            ccRd2,
  output logic      [1:0] ccRp1Lvl,
  output logic      [1:0] ccRp2Lvl,
  output logic            vbusPresent
);
  // only the channel line reaches the far end; a pull-down is seen only
  // while our pull-up biases that line, so a wrong pull-up shows up
  assign ccRd1 = sinkOn & ~flip & rpEnable1;
  assign ccRd2 = sinkOn & flip & rpEnable2;
  // far pull-up is read only through our own pull-down
  assign ccRp1Lvl = (srcOn & ~flip & rdEnable1) ? lvl : 2'h0;
  assign ccRp2Lvl = (srcOn & flip & rdEnable2) ? lvl : 2'h0;
  // shared bus: whichever end switches it on, both see it
  assign vbusPresent = vbusOn | vbusEnable;
endmodule // ccpr_partner

// >>> dv/test_cc_port_role_logic.sv
// self-checking bench of the port role logic against a partner model
`timescale 1ns/1ps
`include "ccpr_defines.svh"
module test_cc_port_role_logic;
  logic clock, arst_n, regWrite, regRead, ccRd1, ccRd2, vbusPresent;
  logic [3:0]  regAddr;
  logic [31:0] regWdata, regRdata, rv;
  logic [1:0]  ccRp1Lvl, ccRp2Lvl, rpLevel, sinkLimit, lvl;
  logic rpEnable1, rpEnable2, rdEnable1, rdEnable2, vbusEnable;
  logic vconnEnable1, vconnEnable2, muxFlip, hostRole, pdEnable;
  logic sinkOn, srcOn, vbusOn, flip;
  logic [7:0] rnd;
  int fail_count, comparisons, n;
  // ************************
  // design, partner, clock
  // ************************
  // duty share keeps its default; only the spans are shortened
  ccpr_port_role #(.CC_DEB_CYC(8), .PD_DEB_CYC(4), .DRP_CYC(100),
    .HOLD_CYC(50), .TRY_CYC(60)) uut (
    .clock(clock), .arst_n(arst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .ccRd1(ccRd1), .ccRd2(ccRd2),
    .ccRp1Lvl(ccRp1Lvl), .ccRp2Lvl(ccRp2Lvl), .vbusPresent(vbusPresent),
    .rpEnable1(rpEnable1), .rpEnable2(rpEnable2), .rpLevel(rpLevel),
    .rdEnable1(rdEnable1), .rdEnable2(rdEnable2), .vbusEnable(vbusEnable),
    .vconnEnable1(vconnEnable1), .vconnEnable2(vconnEnable2),
    .muxFlip(muxFlip), .hostRole(hostRole), .sinkLimit(sinkLimit),
    .pdEnable(pdEnable));
  ccpr_partner far (.sinkOn(sinkOn), .srcOn(srcOn), .vbusOn(vbusOn),
    .flip(flip), .lvl(lvl), .rpEnable1(rpEnable1), .rpEnable2(rpEnable2),
    .rdEnable1(rdEnable1), .rdEnable2(rdEnable2), .vbusEnable(vbusEnable),
    .ccRd1(ccRd1), .ccRd2(ccRd2), .ccRp1Lvl(ccRp1Lvl),
    .ccRp2Lvl(ccRp2Lvl), .vbusPresent(vbusPresent));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // ************************
  // helpers
  // ************************
  // 8-bit feedback shift register, seed 32
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one-cycle strobes, changed right after the edge
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr <= a; regWdata <= d; regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    regAddr <= a; regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 rv = regRdata;
  endtask
  // bounded wait for an output level, timeout counts as a mismatch;
  // looks only where outputs are settled, so it stops on the first
  // cycle that shows the level
  task automatic waitFor(ref logic s, input logic v, input int lim);
    for (n = 0; n < lim && s !== v; n++) idle(1);
    chk(s, v);
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge clock);
    #1;
  endtask
  task automatic results;
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog: whole sequence needs about a thousand cycles
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    results;
  end
  // ************************
  // main sequence
  // ************************
  initial begin
    {regAddr, regWdata, regWrite, regRead} = '0;
    {sinkOn, srcOn, vbusOn, flip, lvl} = '0;
    fail_count = 0; comparisons = 0; rnd = 8'h20;
    arst_n = 1'b0;
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    rd(`CCPR_OFF_CTRL); chk(rv, 32'h2);
    rd(4'hc); chk(rv, 32'h0);
    chk(vbusEnable, 1'b0);
    // dual role phases: source share, then sink share, each +1
    waitFor(rpEnable1, 1'b0, 200);
    waitFor(rpEnable1, 1'b1, 200);
    for (n = 0; rpEnable1 === 1'b1 && n < 200; n++) idle(1);
    chk(n, 31);
    for (n = 0; rpEnable1 === 1'b0 && n < 200; n++) idle(1);
    chk(n, 71);
    // source mode, random pull-up strength
    rnd = lfsr(rnd);
    wr(`CCPR_OFF_CTRL, {26'h0, rnd[1:0], 4'h0});
    idle(3);
    chk({rpEnable1, rpEnable2, rdEnable1, rdEnable2}, 4'hc);
    chk(rpLevel, rnd[1:0]);
    // short pull-down glitch must not attach
    flip <= 1'b1; sinkOn <= 1'b1; idle(3); sinkOn <= 1'b0;
    idle(30); chk(vbusEnable, 1'b0);
    sinkOn <= 1'b1;
    waitFor(vbusEnable, 1'b1, 40);
    chk({muxFlip, vconnEnable1, vconnEnable2}, 3'h6);
    chk({hostRole, pdEnable}, 2'h3);
    chk(pdEnable, 1'b1);
    rnd = lfsr(rnd);
    wr(`CCPR_OFF_CTRL, {26'h0, rnd[1:0], 4'h0}); idle(2);
    chk(rpLevel, rnd[1:0]);
    wr(`CCPR_OFF_CMD, 32'h1 << `CCPR_CMD_DR); idle(2);
    chk({hostRole, vbusEnable, vconnEnable1, rpEnable2}, 4'h7);
    wr(`CCPR_OFF_CMD, 32'h1 << `CCPR_CMD_VC); idle(2);
    chk({hostRole, vbusEnable, vconnEnable1, rpEnable2}, 4'h5);
    sinkOn <= 1'b0;
    waitFor(vbusEnable, 1'b0, 40);
    chk({vconnEnable1, vconnEnable2, rpEnable1, rpEnable2}, 4'h3);
    // sink mode: pull-up alone does not attach, supply does
    wr(`CCPR_OFF_CTRL, 32'h1); idle(3);
    chk({rpEnable1, rpEnable2, rdEnable1, rdEnable2}, 4'h3);
    rnd = lfsr(rnd);
    lvl <= (rnd[1:0] == 2'h0) ? 2'h1 : rnd[1:0];
    flip <= 1'b0; srcOn <= 1'b1; idle(30);
    chk(pdEnable, 1'b0);
    vbusOn <= 1'b1;
    waitFor(pdEnable, 1'b1, 40);
    chk({muxFlip, hostRole, vbusEnable}, 3'h0);
    chk(sinkLimit, lvl);
    wr(`CCPR_OFF_CMD, 32'h1 << `CCPR_CMD_PR); idle(2);
    chk({rpEnable1, rdEnable1, hostRole, vconnEnable1}, 4'h8);
    srcOn <= 1'b0; vbusOn <= 1'b0; idle(40);
    // dual role meets a sink: no toggling for 60 cycles while attached
    wr(`CCPR_OFF_CTRL, 32'h2); flip <= 1'b0; sinkOn <= 1'b1;
    waitFor(vbusEnable, 1'b1, 300);
    for (n = 0; n < 60 && rdEnable1 !== 1'b1; n++) idle(1);
    chk(n, 60);
    chk(vconnEnable2, 1'b1);
    sinkOn <= 1'b0;
    waitFor(vbusEnable, 1'b0, 40);
    idle(1); chk(rpEnable1, 1'b1);
    // dual role sees a source: stays sink
    srcOn <= 1'b1; vbusOn <= 1'b1;
    waitFor(pdEnable, 1'b1, 400);
    idle(150);
    chk({rdEnable1, rpEnable1, hostRole, pdEnable}, 4'h9);
    srcOn <= 1'b0; vbusOn <= 1'b0; idle(10);
    // sink preference: sink found while source, sink tried once
    wr(`CCPR_OFF_CTRL, 32'h0a);
    sinkOn <= 1'b1;
    waitFor(rdEnable1, 1'b1, 100);
    // partner turns source as a dual role port would
    sinkOn <= 1'b0;
    srcOn <= 1'b1;
    vbusOn <= 1'b1;
    waitFor(pdEnable, 1'b1, 100);
    chk({rdEnable1, hostRole, vbusEnable, muxFlip}, 4'h8);
    rd(`CCPR_OFF_STAT);
    chk(rv[12], 1'b1);
    chk(rv[3:0], 4'h6);
    srcOn <= 1'b0;
    vbusOn <= 1'b0;
    waitFor(pdEnable, 1'b0, 40);
    rd(`CCPR_OFF_STAT);
    chk(rv[12], 1'b0);
    // source preference: source found while sink, source tried once
    wr(`CCPR_OFF_CTRL, 32'h06);
    srcOn <= 1'b1;
    vbusOn <= 1'b1;
    waitFor(rdEnable1, 1'b1, 100);
    waitFor(rpEnable1, 1'b1, 100);
    srcOn <= 1'b0;
    vbusOn <= 1'b0;
    sinkOn <= 1'b1;
    waitFor(vbusEnable, 1'b1, 100);
    chk({hostRole, rdEnable1, vconnEnable2}, 3'h5);
    rd(`CCPR_OFF_STAT);
    chk(rv[12], 1'b1);
    chk(rv[3:0], 4'h2);
    // power swap as source: data role and cable power kept
    wr(`CCPR_OFF_CMD, 32'h1 << `CCPR_CMD_PR);
    idle(2);
    chk({rpEnable1, rdEnable1, hostRole, vconnEnable2}, 4'h7);
    sinkOn <= 1'b0;
    waitFor(pdEnable, 1'b0, 40);
    // disabled port shows no termination at all
    wr(`CCPR_OFF_CTRL, 32'h40);
    idle(3);
    chk({rpEnable1, rpEnable2, rdEnable1, rdEnable2}, 4'h0);
    results;
  end
endmodule // test_cc_port_role_logic

// >>> rtl/ccpr_defines.svh
// offsets, field positions, reset values and timing counts of port role logic
`ifndef CCPR_DEFINES_SVH
`define CCPR_DEFINES_SVH

// register offsets
`define CCPR_OFF_CTRL 4'h0
`define CCPR_OFF_CMD 4'h4
`define CCPR_OFF_STAT 4'h8

// control fields and reset value
`define CCPR_CTRL_W 7
`define CCPR_CTRL_RST 7'h02
`define CCPR_CTRL_TRYSRC 2
`define CCPR_CTRL_TRYSNK 3
`define CCPR_CTRL_DISABLE 6
`define CCPR_MODE_SRC 2'h0
`define CCPR_MODE_SNK 2'h1
`define CCPR_MODE_DRP 2'h2

// command bits, self clearing
`define CCPR_CMD_PR 0
`define CCPR_CMD_DR 1
`define CCPR_CMD_VC 2

// timing, figure in microseconds, count in cycles
`define CCPR_CLK_MHZ 100
`define CCPR_T_CCDEB_US 150
`define CCPR_T_PDDEB_US 10
`define CCPR_T_DRP_US 75000
`define CCPR_DC_SRC_PCT 30
`define CCPR_T_HOLD_US 100000
`define CCPR_T_TRY_US 100000
`define CCPR_CCDEB_CYC (`CCPR_T_CCDEB_US * `CCPR_CLK_MHZ)
`define CCPR_PDDEB_CYC (`CCPR_T_PDDEB_US * `CCPR_CLK_MHZ)
`define CCPR_DRP_CYC (`CCPR_T_DRP_US * `CCPR_CLK_MHZ)
`define CCPR_HOLD_CYC (`CCPR_T_HOLD_US * `CCPR_CLK_MHZ)
`define CCPR_TRY_CYC (`CCPR_T_TRY_US * `CCPR_CLK_MHZ)

`endif

// >>> rtl/ccpr_pkg.sv
// types shared by the port role logic
package ccpr_pkg;
  // connection states
  typedef enum logic [3:0] {
    UNATT_SRC, AW_SRC, ATT_SRC, TRY_SRC,
    UNATT_SNK, AW_SNK, ATT_SNK, TRY_SNK, DISABLED
  } ccpr_state_type;
endpackage

// >>> rtl/ccpr_port_role.sv
// port role logic: terminations, attach, orientation, power and swaps
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "ccpr_defines.svh"

module ccpr_port_role #(
  parameter int unsigned CC_DEB_CYC = `CCPR_CCDEB_CYC,
  parameter int unsigned PD_DEB_CYC = `CCPR_PDDEB_CYC,
  parameter int unsigned DRP_CYC    = `CCPR_DRP_CYC,
  parameter int unsigned DC_SRC_PCT = `CCPR_DC_SRC_PCT,
  parameter int unsigned HOLD_CYC   = `CCPR_HOLD_CYC,
  parameter int unsigned TRY_CYC    = `CCPR_TRY_CYC
)(
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdata,
  input  wire logic        ccRd1,
  input  wire logic        ccRd2,
  input  wire logic [1:0]  ccRp1Lvl,
  input  wire logic [1:0]  ccRp2Lvl,
  input  wire logic        vbusPresent,
  output logic             rpEnable1,
  output logic             rpEnable2,
  output logic      [1:0]  rpLevel,
  output logic             rdEnable1,
  output logic             rdEnable2,
  output logic             vbusEnable,
  output logic             vconnEnable1,
  output logic             vconnEnable2,
  output logic             muxFlip,
  output logic             hostRole,
  output logic      [1:0]  sinkLimit,
  output logic             pdEnable
);

  // ***************************************************
  // helpers
  // ***************************************************
  localparam int unsigned SRC_PH = (DRP_CYC * DC_SRC_PCT) / 100;
  localparam int unsigned SNK_PH = DRP_CYC - SRC_PH;

  // states that present pull-ups
  function automatic logic isSrc(ccpr_pkg::ccpr_state_type s);
    return s == ccpr_pkg::UNATT_SRC || s == ccpr_pkg::AW_SRC ||
           s == ccpr_pkg::ATT_SRC || s == ccpr_pkg::TRY_SRC;
  endfunction

  // states with a settled connection
  function automatic logic isAtt(ccpr_pkg::ccpr_state_type s);
    return s == ccpr_pkg::ATT_SRC || s == ccpr_pkg::ATT_SNK;
  endfunction

  // ***************************************************
  // pin synchronisers
  // ***************************************************
  logic [6:0] syncA_r;  // first stage, read only by second
  logic [6:0] syncB_r;  // second stage
  logic [6:0] syncC_r;  // third stage
  logic [6:0] filt_r;   // accepted level

  // three stages; a bit moves once stages two and three agree
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      syncA_r <= 7'h00;
      syncB_r <= 7'h00;
      syncC_r <= 7'h00;
      filt_r  <= 7'h00;
    end else begin
      syncA_r <= {vbusPresent, ccRp2Lvl, ccRp1Lvl, ccRd2, ccRd1};
      syncB_r <= syncA_r;
      syncC_r <= syncB_r;
      filt_r  <= (syncB_r & syncC_r) | (filt_r & (syncB_r | syncC_r));
    end
  end

  logic       rd1F;      // pull-down seen on line 1
  logic       rd2F;      // pull-down seen on line 2
  logic [1:0] rp1F;      // pull-up level on line 1
  logic [1:0] rp2F;      // pull-up level on line 2
  logic       vbusF;     // supply present
  assign {vbusF, rp2F, rp1F, rd2F, rd1F} = filt_r;

  // ***************************************************
  // registers
  // ***************************************************
  logic [`CCPR_CTRL_W-1:0] ctrl_r;  // control word
  logic [1:0] mode;                 // source, sink or dual role
  logic       cmdPr;                // power swap request
  logic       cmdDr;                // data swap request
  logic       cmdVc;                // cable power swap request
  logic       cmdWr;                // write to command word

  assign mode  = ctrl_r[1:0];
  assign cmdWr = regWrite && regAddr == `CCPR_OFF_CMD;
  assign cmdPr = cmdWr && regWdata[`CCPR_CMD_PR];
  assign cmdDr = cmdWr && regWdata[`CCPR_CMD_DR];
  assign cmdVc = cmdWr && regWdata[`CCPR_CMD_VC];

  // control word; level and role settings steer the logic
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= `CCPR_CTRL_RST;
    end else if (regWrite && regAddr == `CCPR_OFF_CTRL) begin
      ctrl_r <= regWdata[`CCPR_CTRL_W-1:0];
    end
  end

  // ***************************************************
  // connection state machine
  // ***************************************************
  ccpr_pkg::ccpr_state_type state_r;    // current state
  ccpr_pkg::ccpr_state_type state_nxt;  // next state
  ccpr_pkg::ccpr_state_type initSt;     // start of toggling
  logic [31:0] timer_r;     // cycles in state or line lost
  logic [31:0] holdLeft_r;  // source hold after attach
  logic        tried_r;     // preference swap used
  logic        flip_r;      // plug orientation
  logic        vconnOwn_r;  // this end powers the cable
  logic        host_r;      // data role is host
  logic        rdAny;       // pull-down on either line
  logic        rdAct;       // pull-down on the chosen line
  logic        rpAny;       // pull-up on either line
  logic [1:0]  rpActLvl;    // pull-up level on chosen line
  logic        attEntry;    // first entry to an attached state

  assign rdAny    = rd1F | rd2F;
  assign rdAct    = flip_r ? rd2F : rd1F;
  assign rpAny    = (|rp1F) | (|rp2F);
  assign rpActLvl = flip_r ? rp2F : rp1F;
  assign initSt   = (mode == `CCPR_MODE_SNK) ? ccpr_pkg::UNATT_SNK
                                             : ccpr_pkg::UNATT_SRC;
  assign attEntry = isAtt(state_nxt) && !isAtt(state_r);

  // next state; detach returns to the first presentation
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ccpr_pkg::UNATT_SRC: begin
        if (mode == `CCPR_MODE_SNK) begin
          state_nxt = ccpr_pkg::UNATT_SNK;
        end else if (rdAny) begin
          state_nxt = ccpr_pkg::AW_SRC;
        end else if (mode == `CCPR_MODE_DRP && holdLeft_r == 32'h0 &&
                     timer_r >= SRC_PH) begin
          state_nxt = ccpr_pkg::UNATT_SNK;
        end
      end
      ccpr_pkg::AW_SRC: begin
        if (!rdAny) begin
          state_nxt = ccpr_pkg::UNATT_SRC;
        end else if (timer_r >= CC_DEB_CYC) begin
          if (mode == `CCPR_MODE_DRP && ctrl_r[`CCPR_CTRL_TRYSNK] &&
              !tried_r) begin
            state_nxt = ccpr_pkg::TRY_SNK;
          end else begin
            state_nxt = ccpr_pkg::ATT_SRC;
          end
        end
      end
      ccpr_pkg::ATT_SRC: begin
        if (cmdPr) begin
          state_nxt = ccpr_pkg::ATT_SNK;
        end else if (timer_r >= PD_DEB_CYC) begin
          state_nxt = initSt;
        end
      end
      ccpr_pkg::TRY_SRC: begin
        if (rdAny && timer_r >= CC_DEB_CYC) begin
          state_nxt = ccpr_pkg::ATT_SRC;
        end else if (timer_r >= TRY_CYC) begin
          state_nxt = ccpr_pkg::UNATT_SNK;
        end
      end
      ccpr_pkg::UNATT_SNK: begin
        if (mode == `CCPR_MODE_SRC) begin
          state_nxt = ccpr_pkg::UNATT_SRC;
        end else if (vbusF) begin
          state_nxt = ccpr_pkg::AW_SNK;
        end else if (mode == `CCPR_MODE_DRP && timer_r >= SNK_PH) begin
          state_nxt = ccpr_pkg::UNATT_SRC;
        end
      end
      ccpr_pkg::AW_SNK: begin
        if (!vbusF) begin
          state_nxt = ccpr_pkg::UNATT_SNK;
        end else if (rpAny && timer_r >= CC_DEB_CYC) begin
          if (mode == `CCPR_MODE_DRP && ctrl_r[`CCPR_CTRL_TRYSRC] &&
              !tried_r) begin
            state_nxt = ccpr_pkg::TRY_SRC;
          end else begin
            state_nxt = ccpr_pkg::ATT_SNK;
          end
        end
      end
      ccpr_pkg::ATT_SNK: begin
        if (cmdPr) begin
          state_nxt = ccpr_pkg::ATT_SRC;
        end else if (!vbusF) begin
          state_nxt = initSt;
        end
      end
      ccpr_pkg::TRY_SNK: begin
        if (vbusF && timer_r >= CC_DEB_CYC) begin
          state_nxt = ccpr_pkg::ATT_SNK;
        end else if (timer_r >= TRY_CYC) begin
          state_nxt = ccpr_pkg::UNATT_SRC;
        end
      end
      ccpr_pkg::DISABLED: begin
        state_nxt = initSt;
      end
      default: state_nxt = ccpr_pkg::UNATT_SRC;
    endcase
    // disable overrides every state
    if (ctrl_r[`CCPR_CTRL_DISABLE]) begin
      state_nxt = ccpr_pkg::DISABLED;
    end
  end

  // state register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ccpr_pkg::UNATT_SRC;
    end else begin
      state_r <= state_nxt;
    end
  end

  // timer; as attached source it counts pull-down absence,
  // so short signalling edges on the line are ridden out
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      timer_r <= 32'h0;
    end else if (state_nxt != state_r ||
                 (state_r == ccpr_pkg::ATT_SRC && rdAct)) begin
      timer_r <= 32'h0;
    end else if (timer_r != 32'hffffffff) begin
      timer_r <= timer_r + 32'h1;
    end
  end

  // source hold: no toggling soon after a source attach
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      holdLeft_r <= 32'h0;
    end else if (attEntry && state_nxt == ccpr_pkg::ATT_SRC &&
                 mode == `CCPR_MODE_DRP) begin
      holdLeft_r <= HOLD_CYC;
    end else if (holdLeft_r != 32'h0) begin
      holdLeft_r <= holdLeft_r - 32'h1;
    end
  end

  // preference swap record, cleared by detach
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tried_r <= 1'b0;
    end else if (state_nxt == ccpr_pkg::TRY_SRC ||
                 state_nxt == ccpr_pkg::TRY_SNK) begin
      tried_r <= 1'b1;
    end else if (isAtt(state_r) && !isAtt(state_nxt)) begin
      tried_r <= 1'b0;
    end
  end

  // orientation and roles fixed at attach; swaps flip one each
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flip_r     <= 1'b0;
      vconnOwn_r <= 1'b0;
      host_r     <= 1'b0;
    end else if (attEntry && state_nxt == ccpr_pkg::ATT_SRC) begin
      flip_r     <= rd2F && !rd1F;
      vconnOwn_r <= 1'b1;
      host_r     <= 1'b1;
    end else if (attEntry) begin
      flip_r     <= (|rp2F) && !(|rp1F);
      vconnOwn_r <= 1'b0;
      host_r     <= 1'b0;
    end else if (!isAtt(state_nxt)) begin
      vconnOwn_r <= 1'b0;
    end else begin
      // power swap leaves these alone
      if (cmdDr) host_r <= !host_r;
      if (cmdVc) vconnOwn_r <= !vconnOwn_r;
    end
  end

  // ***************************************************
  // pin drivers
  // ***************************************************
  // terminations, power and mux from the settled state
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rpEnable1    <= 1'b0;
      rpEnable2    <= 1'b0;
      rdEnable1    <= 1'b0;
      rdEnable2    <= 1'b0;
      rpLevel      <= 2'h0;
      vbusEnable   <= 1'b0;
      vconnEnable1 <= 1'b0;
      vconnEnable2 <= 1'b0;
      muxFlip      <= 1'b0;
      hostRole     <= 1'b0;
      sinkLimit    <= 2'h0;
      pdEnable     <= 1'b0;
    end else begin
      // pull-up dropped on the pin that powers the cable
      rpEnable1    <= isSrc(state_r) && !(vconnOwn_r && flip_r);
      rpEnable2    <= isSrc(state_r) && !(vconnOwn_r && !flip_r);
      rdEnable1    <= !isSrc(state_r) &&
                      state_r != ccpr_pkg::DISABLED;
      rdEnable2    <= !isSrc(state_r) && state_r != ccpr_pkg::DISABLED;
      rpLevel      <= ctrl_r[5:4];
      vbusEnable   <= state_r == ccpr_pkg::ATT_SRC;
      vconnEnable1 <= vconnOwn_r && flip_r;
      vconnEnable2 <= vconnOwn_r && !flip_r;
      muxFlip      <= flip_r;
      hostRole     <= host_r;
      sinkLimit    <= (state_r == ccpr_pkg::ATT_SNK) ? rpActLvl
                                                     : 2'h0;
      pdEnable     <= isAtt(state_r);
    end
  end

  // ***************************************************
  // read port
  // ***************************************************
  // data valid only in the cycle after the strobe
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= 32'h0;
    end else if (regRead && regAddr == `CCPR_OFF_CTRL) begin
      regRdata <= {25'h0, ctrl_r};
    end else if (regRead && regAddr == `CCPR_OFF_STAT) begin
      regRdata <= {19'h0, tried_r, sinkLimit, vbusEnable, vconnOwn_r,
                   host_r, isSrc(state_r), flip_r, isAtt(state_r),
                   state_r};
    end else begin
      regRdata <= 32'h0;  // unmapped or no read
    end
  end

  // ***************************************************
  // assertions
  // ***************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  a_vbus_only_src: assert property (
    vbusEnable |-> $past(state_r) == ccpr_pkg::ATT_SRC)
    else $error("supply on outside attached source");
  a_vbus_on_att: assert property (
    state_r == ccpr_pkg::ATT_SRC |=> vbusEnable && pdEnable)
    else $error("supply not on as attached source");
  a_sink_pulldown: assert property (
    state_r == ccpr_pkg::UNATT_SNK |=> rdEnable1 && rdEnable2 &&
      !rpEnable1 && !rpEnable2)
    else $error("sink terminations wrong");
  a_rp_level: assert property (
    ##1 rpLevel == $past(ctrl_r[5:4]))
    else $error("pull-up level not following control");
  a_vconn_side: assert property (
    vconnEnable1 |-> muxFlip && !vconnEnable2)
    else $error("cable power on wrong pin");
  a_detach_deb: assert property (
    state_r == ccpr_pkg::ATT_SRC && !cmdPr &&
      state_nxt != ccpr_pkg::ATT_SRC && !ctrl_r[`CCPR_CTRL_DISABLE]
      |-> timer_r >= PD_DEB_CYC)
    else $error("source detach not debounced");
  a_sink_vbus: assert property (
    attEntry && state_nxt == ccpr_pkg::ATT_SNK |-> vbusF)
    else $error("sink attach without supply");
  a_sink_limit: assert property (
    state_r == ccpr_pkg::ATT_SNK |=> sinkLimit == $past(rpActLvl))
    else $error("sink limit not from pull-up level");
  a_try_once: assert property (
    state_nxt inside {ccpr_pkg::TRY_SRC, ccpr_pkg::TRY_SNK} &&
      state_r != state_nxt |-> !tried_r)
    else $error("preference swap tried twice");
  a_pr_swap: assert property (
    state_r == ccpr_pkg::ATT_SRC && cmdPr && !ctrl_r[6]
      |=> state_r == ccpr_pkg::ATT_SNK && $stable(host_r) &&
          $stable(vconnOwn_r))
    else $error("power swap changed other roles");
  a_dr_swap: assert property (
    isAtt(state_r) && isAtt(state_nxt) && cmdDr && !cmdPr
      |=> host_r != $past(host_r) && $stable(state_r))
    else $error("data swap wrong");

  c_src_attach: cover property (state_r == ccpr_pkg::ATT_SRC);
  c_snk_attach: cover property (state_r == ccpr_pkg::ATT_SNK);
  c_try_src: cover property (state_r == ccpr_pkg::TRY_SRC);
  c_pr_swap: cover property (isAtt(state_r) && cmdPr);

endmodule // ccpr_port_role
